// File: hdl/rail_seq_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the rail sequencer
// Assumes: 8-bit register space, 40 MHz system clock
// Notes:   included by bare name
`ifndef RAIL_SEQ_CFG_SVH
`define RAIL_SEQ_CFG_SVH

// register offsets
`define RAIL_CFG_BASE   8'h20
`define RAIL_DLY_BASE   8'h30
`define TREE_BASE       8'h40
`define OUT_CFG_BASE    8'h48
`define OUT_LEVEL       8'h4C
`define SLEEP_CFG       8'h4D
`define BUCK_VID        8'h50
`define BUCK_SLEEP_VID  8'h51
`define STAT_GOOD_LO    8'h60
`define STAT_GOOD_HI    8'h61
`define STAT_EN_LO      8'h62
`define STAT_EN_HI      8'h63
`define SW_EN_LO        8'h64
`define SW_EN_HI        8'h65
`define LDO_SEL_A       8'h9A
`define LDO_SEL_B       8'h9B
`define LDO_SEL_C       8'hAE

// field positions
`define CFG_SWM_BIT     3
`define OUT_MAN_BIT     7
`define LDO1_RAIL       6

// reset values
`define RST_BYTE        8'h00
`define RST_VID         7'h00
`define RST_LDO         4'h0
`define LDO1_UNUSED     4'hF

// timing
`define CLK_KHZ         40000
`define TICK_MS         1
`define UV_DELAY_NS     444
`define UV_CYC          ((`UV_DELAY_NS * `CLK_KHZ) / 1000000)
`define OUT1_MAX_MS     15
`define OUT3_MIN_MS     5
`define OUT_MAX_MS      100

`endif

// File: hdl/rail_seq_pkg.sv
// Purpose: shared types of the rail sequencer
// Assumes: nothing
// Notes:   constants live in rail_seq_cfg.svh
package rail_seq_pkg;
	typedef logic [6:0]  vid_code_t;
	typedef logic [3:0]  ldo_code_t;
	typedef logic [11:0] rail_vec_t;
	typedef logic [3:0]  dly_ms_t;
	typedef logic [6:0]  out_dly_t;
endpackage

// File: hdl/rail_sequencer_power_good.sv
// Purpose: rail enable sequencing, power-good tree and voltage-code registers
// Assumes: host bus protocol decoded outside into a simple write/read port
// Notes:   rails 0-5 bucks, 6-8 general LDOs (6 = first), 9-11 load switches
`timescale 1ns/1ps
`include "rail_seq_cfg.svh"

// How it works
// - rail enable from pin, prior good, software
// - software mode drives rail enable directly
// - six pins, twelve rails, group per rail
// - sleep pins swap first buck voltage code
// - prior rail good combined with pin
// - programmable delay before enable asserts
// - automatic power-up only with valid supply
// - early pin waits for needed good
// - separate disable delay on pin fall
// - per-rail good into trees, readable status
// - clamped output assertion delay per output
// - outputs can be host-written plain levels
// - linear code for second, third LDO
// - first LDO code 1111 unused
// - LDO codes written at three offsets
// - always-on first LDO survives emergency shutdown
// - undervoltage: goods drop, rails off later
module rail_sequencer_power_good #(
	parameter int NRAIL       = 12,                       // rail count
	parameter int NCTL        = 6,                        // control inputs
	parameter int NGPO        = 4,                        // general outputs
	parameter int TICK_W      = 16,                       // timebase counter width
	parameter int TICK_CYCLES = `TICK_MS * `CLK_KHZ       // cycles per ms tick
) (
	input  wire logic                      i_clk_sys,          // 40 MHz clock
	input  wire logic                      i_nrst,             // sync reset, active low
	input  wire logic [NCTL-1:0]           i_control_input,    // control pins, async
	input  wire logic [NRAIL-1:0]          i_rail_good,        // per-rail good, async
	input  wire logic                      i_supply_valid,     // system supply valid, async
	input  wire logic                      i_emergency,        // emergency shutdown request, async
	input  wire logic                      i_ldo1_always_on,   // factory strap, async
	input  wire logic                      i_reg_wr,           // register write strobe
	input  wire logic [7:0]                i_reg_addr,         // register offset
	input  wire logic [7:0]                i_reg_wdata,        // write data
	output logic      [7:0]                o_reg_rdata,        // read data, one cycle late
	output logic      [NRAIL-1:0]          o_rail_en,          // internal rail enables
	output logic      [NGPO-1:0]           o_general_output,   // power good / plain outputs
	output rail_seq_pkg::vid_code_t        o_first_buck_vid,   // active first buck code
	output rail_seq_pkg::ldo_code_t        o_ldo_code_a,       // first LDO code
	output rail_seq_pkg::ldo_code_t        o_ldo_code_b,       // second LDO code
	output rail_seq_pkg::ldo_code_t        o_ldo_code_c        // third LDO code
);
	localparam int NSYNC = NCTL + NRAIL + 3;
	localparam int UVC   = `UV_CYC;

	// select bit idx-1 of vec; 0 means no term, out of range never true
	function automatic logic sel_term(input logic [3:0] idx, input logic [NRAIL-1:0] vec);
		if (idx == 4'h0)
			return 1'b1;
		else if (int'(idx) > NRAIL)
			return 1'b0;
		else
			return vec[idx-4'h1];
	endfunction

	// clamp a raw millisecond figure to the range of output k
	function automatic logic [6:0] out_dly(input int k, input logic [6:0] raw);
		logic [6:0] lo;
		logic [6:0] hi;
		lo = (k == 2) ? 7'(`OUT3_MIN_MS) : 7'h00;
		hi = (k == 0) ? 7'(`OUT1_MAX_MS) : 7'(`OUT_MAX_MS);
		if (raw < lo)
			return lo;
		else if (raw > hi)
			return hi;
		else
			return raw;
	endfunction

	logic [NSYNC-1:0]       s1_q;
	logic [NSYNC-1:0]       s2_q;
	logic [NCTL-1:0]        ctl_s;
	logic [NRAIL-1:0]       rg_s;
	logic                   supply_s;
	logic                   emerg_s;
	logic                   aon_s;
	logic [TICK_W-1:0]      tick_cnt_q;
	logic                   tick;
	logic [4:0]             uv_cnt_q;
	logic                   uv_done;
	logic [7:0]             cfg_q [NRAIL];
	logic [7:0]             dly_q [NRAIL];
	logic [7:0]             tree_q [2*NGPO];
	logic [7:0]             gcfg_q [NGPO];
	logic [NGPO-1:0]        glvl_q;
	logic [1:0]             slp_cfg_q;
	logic [NRAIL-1:0]       sw_en_q;
	rail_seq_pkg::vid_code_t vid_q;
	rail_seq_pkg::vid_code_t slp_vid_q;
	rail_seq_pkg::ldo_code_t ldo_a_q;
	rail_seq_pkg::ldo_code_t ldo_b_q;
	rail_seq_pkg::ldo_code_t ldo_c_q;
	rail_seq_pkg::dly_ms_t  cnt_q [NRAIL];
	rail_seq_pkg::out_dly_t gcnt_q [NGPO];
	logic [NRAIL-1:0]       auto_on;
	logic [NRAIL-1:0]       kill;
	logic [NGPO-1:0]        tree_good;
	logic                   sleep_act;
	logic [7:0]             rd_d;

	// two-flop synchroniser; only the second stage is read
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= {i_ldo1_always_on, i_emergency, i_supply_valid, i_rail_good, i_control_input};
			s2_q <= s1_q;
		end
	end
	assign ctl_s    = s2_q[NCTL-1:0];
	assign rg_s     = s2_q[NCTL+NRAIL-1:NCTL];
	assign supply_s = s2_q[NCTL+NRAIL];
	assign emerg_s  = s2_q[NCTL+NRAIL+1];
	assign aon_s    = s2_q[NCTL+NRAIL+2];

	// millisecond timebase, held at zero while the supply is invalid
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst || !supply_s)
			tick_cnt_q <= '0;
		else if (tick)
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + TICK_W'(1);
	end
	assign tick = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));

	// undervoltage shutdown delay; rails hold until it runs out
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst || supply_s)
			uv_cnt_q <= 5'h00;
		else if (uv_cnt_q != 5'(UVC))
			uv_cnt_q <= uv_cnt_q + 5'h01;
	end
	assign uv_done = (uv_cnt_q == 5'(UVC));

	// host register writes
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			for (int i = 0; i < NRAIL; i++) begin
				cfg_q[i] <= `RST_BYTE;
				dly_q[i] <= `RST_BYTE;
			end
			for (int i = 0; i < 2*NGPO; i++)
				tree_q[i] <= `RST_BYTE;
			for (int i = 0; i < NGPO; i++)
				gcfg_q[i] <= `RST_BYTE;
			glvl_q    <= '0;
			slp_cfg_q <= 2'h0;
			sw_en_q   <= '0;
			vid_q     <= `RST_VID;
			slp_vid_q <= `RST_VID;
			ldo_a_q   <= `RST_LDO;
			ldo_b_q   <= `RST_LDO;
			ldo_c_q   <= `RST_LDO;
		end else if (i_reg_wr) begin
			for (int i = 0; i < NRAIL; i++) begin
				if (i_reg_addr == 8'(`RAIL_CFG_BASE + i))
					cfg_q[i] <= i_reg_wdata;
				if (i_reg_addr == 8'(`RAIL_DLY_BASE + i))
					dly_q[i] <= i_reg_wdata;
			end
			for (int i = 0; i < 2*NGPO; i++)
				if (i_reg_addr == 8'(`TREE_BASE + i))
					tree_q[i] <= (i[0]) ? {4'h0, i_reg_wdata[3:0]} : i_reg_wdata;
			for (int i = 0; i < NGPO; i++)
				if (i_reg_addr == 8'(`OUT_CFG_BASE + i))
					gcfg_q[i] <= i_reg_wdata;
			case (i_reg_addr)
				`OUT_LEVEL:     glvl_q <= i_reg_wdata[NGPO-1:0];
				`SLEEP_CFG:     slp_cfg_q <= i_reg_wdata[1:0];
				`BUCK_VID:      vid_q <= i_reg_wdata[6:0];
				`BUCK_SLEEP_VID: slp_vid_q <= i_reg_wdata[6:0];
				`SW_EN_LO:      sw_en_q[7:0] <= i_reg_wdata;
				`SW_EN_HI:      sw_en_q[NRAIL-1:8] <= i_reg_wdata[NRAIL-9:0];
				`LDO_SEL_A: begin
					// an unused code would leave the first LDO undefined, so it is dropped
					if (i_reg_wdata[3:0] != `LDO1_UNUSED)
						ldo_a_q <= i_reg_wdata[3:0];
				end
				`LDO_SEL_B:     ldo_b_q <= i_reg_wdata[3:0];
				`LDO_SEL_C:     ldo_c_q <= i_reg_wdata[3:0];
				default: begin
				end
			endcase
		end
	end

	// registered read mux; unmapped offsets read zero
	always_comb begin
		rd_d = 8'h00;
		for (int i = 0; i < NRAIL; i++) begin
			if (i_reg_addr == 8'(`RAIL_CFG_BASE + i))
				rd_d = cfg_q[i];
			if (i_reg_addr == 8'(`RAIL_DLY_BASE + i))
				rd_d = dly_q[i];
		end
		for (int i = 0; i < 2*NGPO; i++)
			if (i_reg_addr == 8'(`TREE_BASE + i))
				rd_d = tree_q[i];
		for (int i = 0; i < NGPO; i++)
			if (i_reg_addr == 8'(`OUT_CFG_BASE + i))
				rd_d = gcfg_q[i];
		case (i_reg_addr)
			`OUT_LEVEL:     rd_d = {4'h0, glvl_q};
			`SLEEP_CFG:     rd_d = {6'h00, slp_cfg_q};
			`BUCK_VID:      rd_d = {1'b0, vid_q};
			`BUCK_SLEEP_VID: rd_d = {1'b0, slp_vid_q};
			`STAT_GOOD_LO:  rd_d = rg_s[7:0];
			`STAT_GOOD_HI:  rd_d = {4'h0, rg_s[NRAIL-1:8]};
			`STAT_EN_LO:    rd_d = o_rail_en[7:0];
			`STAT_EN_HI:    rd_d = {4'h0, o_rail_en[NRAIL-1:8]};
			`SW_EN_LO:      rd_d = sw_en_q[7:0];
			`SW_EN_HI:      rd_d = {4'h0, sw_en_q[NRAIL-1:8]};
			`LDO_SEL_A:     rd_d = {4'h0, ldo_a_q};
			`LDO_SEL_B:     rd_d = {4'h0, ldo_b_q};
			`LDO_SEL_C:     rd_d = {4'h0, ldo_c_q};
			default:        rd_d = rd_d;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst)
			o_reg_rdata <= 8'h00;
		else
			o_reg_rdata <= rd_d;
	end

	// per-rail automatic enable condition: pin group and prior rail good
	for (genvar r = 0; r < NRAIL; r++) begin : g_cond
		logic [3:0] grp;
		logic [3:0] src;
		assign grp = {1'b0, cfg_q[r][2:0]};
		assign src = cfg_q[r][7:4];
		// both terms zero leaves the rail to software only
		assign auto_on[r] = ((grp != 4'h0) || (src != 4'h0)) && supply_s
			&& sel_term(grp, {{(NRAIL-NCTL){1'b0}}, ctl_s})
			&& sel_term(src, rg_s);
		assign kill[r] = emerg_s && !((r == `LDO1_RAIL) && aon_s);
	end

	// rail enable state with separate up and down delays in ms ticks
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			o_rail_en <= '0;
			for (int r = 0; r < NRAIL; r++)
				cnt_q[r] <= 4'h0;
		end else begin
			for (int r = 0; r < NRAIL; r++) begin
				if (uv_done) begin
					o_rail_en[r] <= 1'b0;
					cnt_q[r]     <= 4'h0;
				end else if (!supply_s) begin
					cnt_q[r] <= 4'h0;
				end else if (kill[r]) begin
					o_rail_en[r] <= 1'b0;
					cnt_q[r]     <= 4'h0;
				end else if (cfg_q[r][`CFG_SWM_BIT]) begin
					o_rail_en[r] <= sw_en_q[r];
					cnt_q[r]     <= 4'h0;
				end else if (o_rail_en[r] == auto_on[r]) begin
					cnt_q[r] <= 4'h0;
				end else if (cnt_q[r] >= (o_rail_en[r] ? dly_q[r][7:4] : dly_q[r][3:0])) begin
					o_rail_en[r] <= auto_on[r];
					cnt_q[r]     <= 4'h0;
				end else if (tick) begin
					cnt_q[r] <= cnt_q[r] + 4'h1;
				end
			end
		end
	end

	// power good trees: all selected rails good, empty tree never good
	for (genvar k = 0; k < NGPO; k++) begin : g_tree
		logic [NRAIL-1:0] mask;
		assign mask = {tree_q[2*k+1][3:0], tree_q[2*k]};
		assign tree_good[k] = (mask != '0) && ((rg_s & mask) == mask);
	end

	// general outputs: delayed assertion, immediate drop, or host level
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			o_general_output <= '0;
			for (int k = 0; k < NGPO; k++)
				gcnt_q[k] <= 7'h00;
		end else begin
			for (int k = 0; k < NGPO; k++) begin
				if (gcfg_q[k][`OUT_MAN_BIT]) begin
					o_general_output[k] <= glvl_q[k];
					gcnt_q[k]           <= 7'h00;
				end else if (!supply_s || !tree_good[k]) begin
					o_general_output[k] <= 1'b0;
					gcnt_q[k]           <= 7'h00;
				end else if (!o_general_output[k]) begin
					if (gcnt_q[k] >= out_dly(k, gcfg_q[k][6:0]))
						o_general_output[k] <= 1'b1;
					else if (tick)
						gcnt_q[k] <= gcnt_q[k] + 7'h01;
				end
			end
		end
	end

	// sleep request pins are active low; either configured pin suffices
	assign sleep_act = (slp_cfg_q[0] && !ctl_s[2]) || (slp_cfg_q[1] && !ctl_s[5]);

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst)
			o_first_buck_vid <= `RST_VID;
		else
			o_first_buck_vid <= sleep_act ? slp_vid_q : vid_q;
	end

	assign o_ldo_code_a = ldo_a_q;
	assign o_ldo_code_b = ldo_b_q;
	assign o_ldo_code_c = ldo_c_q;

	a_sleep_vid: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		sleep_act |=> o_first_buck_vid == $past(slp_vid_q))
		else $error("first buck not on sleep code");

	a_uv_hold: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(!supply_s && !uv_done) |=> $stable(o_rail_en))
		else $error("rails changed before undervoltage delay");

	a_uv_off: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		$fell(supply_s) |-> ##18 (o_rail_en == '0))
		else $error("rails still on after undervoltage delay");

	a_uv_good_low: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(!supply_s && !gcfg_q[0][`OUT_MAN_BIT]) |=> !o_general_output[0])
		else $error("good output high with invalid supply");

	a_tick_hold: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		!supply_s |=> (tick_cnt_q == '0))
		else $error("timebase running with invalid supply");

	a_rise_cause: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		($rose(o_rail_en[1]) && !$past(cfg_q[1][`CFG_SWM_BIT])) |-> $past(auto_on[1]))
		else $error("rail enabled without its condition");

	a_sw_direct: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(cfg_q[0][`CFG_SWM_BIT] && supply_s && !uv_done && !emerg_s) |=> (o_rail_en[0] == $past(sw_en_q[0])))
		else $error("software enable not followed");

	a_good_drop: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(!gcfg_q[1][`OUT_MAN_BIT] && !tree_good[1]) |=> !o_general_output[1])
		else $error("good output not dropped at once");

	a_ldo1_unused: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(i_reg_wr && i_reg_addr == `LDO_SEL_A && i_reg_wdata[3:0] == `LDO1_UNUSED) |=> $stable(ldo_a_q))
		else $error("unused first LDO code accepted");

	a_out_manual: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		gcfg_q[3][`OUT_MAN_BIT] |=> (o_general_output[3] == $past(glvl_q[3])))
		else $error("plain output level not followed");

endmodule // rail_sequencer_power_good

// File: sim/rail_load_model.sv
// Purpose: behavioural set of twelve rails that report good some cycles after enable
// Assumes: one clock shared with the sequencer
// Notes:   good also drops on the same lag, so a slow rail is what the tree sees
`timescale 1ns/1ps
module rail_load_model #(
	parameter int LAG = 3                   // cycles from enable to good
) (
	input  wire logic        i_clk_sys,     // system clock
	input  wire logic [11:0] i_rail_en,     // enables from the sequencer
	output logic      [11:0] o_rail_good    // per-rail good
);
	logic [11:0] pipe_q [LAG];

	// a shift line stands in for soft-start; never faster than the real ramp
	always_ff @(posedge i_clk_sys) begin
		pipe_q[0] <= i_rail_en;
		for (int k = 1; k < LAG; k++) begin
			pipe_q[k] <= pipe_q[k-1];
		end
	end
	assign o_rail_good = pipe_q[LAG-1];
endmodule // rail_load_model

// File: sim/rail_sequencer_power_good_tb_top.sv
// Purpose: directed register and pin sequences for the rail sequencer
// Assumes: ms tick shortened to 4 cycles, rails modelled by rail_load_model
// Notes:   all inputs move 2 ns after the rising edge
`timescale 1ns/1ps
module rail_sequencer_power_good_tb_top;
	logic                      clk = 1'b0;
	logic                      nrst = 1'b0;
	logic                      supply = 1'b0;
	logic                      emerg = 1'b0;
	logic                      strap = 1'b1;
	logic                      wr = 1'b0;
	logic [5:0]                pins = 6'h00;
	logic [7:0]                addr = 8'h00;
	logic [7:0]                wdata = 8'h00;
	logic [7:0]                rdata;
	logic [11:0]               rail_en;
	logic [11:0]               good;
	logic [3:0]                gout;
	rail_seq_pkg::vid_code_t   vid;
	rail_seq_pkg::ldo_code_t   ldo_a;
	rail_seq_pkg::ldo_code_t   ldo_b;
	rail_seq_pkg::ldo_code_t   ldo_c;
	int                        err_count = 0;
	int                        n_tests = 0;

	initial begin
		forever #12.5 clk = ~clk;
	end

	rail_sequencer_power_good #(.TICK_CYCLES(4)) uut (
		.i_clk_sys(clk), .i_nrst(nrst), .i_control_input(pins), .i_rail_good(good),
		.i_supply_valid(supply), .i_emergency(emerg), .i_ldo1_always_on(strap),
		.i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
		.o_rail_en(rail_en), .o_general_output(gout), .o_first_buck_vid(vid),
		.o_ldo_code_a(ldo_a), .o_ldo_code_b(ldo_b), .o_ldo_code_c(ldo_c));

	rail_load_model rails (.i_clk_sys(clk), .i_rail_en(rail_en), .o_rail_good(good));

	task automatic stop_test();
		if (err_count == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("Error: %s expected %h seen %h", name, exp, got);
			err_count++;
		end
	endtask

	// strobe lasts one cycle, then one idle cycle so back-to-back calls never collide
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		cyc(1);
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		cyc(1);
		chk("register read", 12'(exp), 12'(rdata));
	endtask

	function automatic logic pick(input int sel, input int idx);
		return sel ? gout[idx] : rail_en[idx];
	endfunction

	// bounded wait that also flags a level arriving too early
	task automatic wait_for(input int sel, input int idx, input logic val, input int minc, input int maxc);
		int cnt;
		cnt = 0;
		while (pick(sel, idx) !== val && cnt < maxc) begin
			cyc(1);
			cnt++;
		end
		n_tests++;
		if (pick(sel, idx) !== val || cnt < minc) begin
			$display("Error: level %b of %0d/%0d expected in %0d..%0d cycles seen %0d", val, sel, idx, minc, maxc, cnt);
			err_count++;
		end
	endtask

	initial begin
		#(4000 * 25);
		err_count++;
		stop_test();
	end

	initial begin
		cyc(16);
		nrst = 1'b1;
		cyc(1);
		rd_reg(8'h9A, 8'h00);
		wr_reg(8'h9A, 8'h0E);
		wr_reg(8'h9A, 8'h0F);
		wr_reg(8'h9B, 8'h05);
		wr_reg(8'hAE, 8'h0F);
		wr_reg(8'h7F, 8'h55);
		rd_reg(8'h9A, 8'h0E);
		rd_reg(8'h9B, 8'h05);
		rd_reg(8'hAE, 8'h0F);
		rd_reg(8'h7F, 8'h00);
		chk("ldo codes", 12'hE5F, {ldo_a, ldo_b, ldo_c});
		// rail 0 on pin 1 with 3 ms up and 2 ms down, rail 1 on pin 2 after rail 0 good
		wr_reg(8'h20, 8'h01);
		wr_reg(8'h30, 8'h23);
		wr_reg(8'h21, 8'h12);
		wr_reg(8'h40, 8'h01);
		wr_reg(8'h48, 8'h02);
		wr_reg(8'h49, 8'h80);
		wr_reg(8'h4C, 8'h02);
		pins = 6'h03;
		cyc(20);
		chk("enables without supply", 12'h000, rail_en);
		chk("plain output levels", 12'h002, 12'(gout));
		supply = 1'b1;
		wait_for(0, 0, 1'b1, 8, 18);
		chk("early pin rail", 12'h000, 12'(rail_en[1]));
		wait_for(0, 1, 1'b1, 1, 10);
		chk("good output before delay", 12'h000, 12'(gout[0]));
		wait_for(1, 0, 1'b1, 0, 14);
		rd_reg(8'h60, 8'h03);
		rd_reg(8'h62, 8'h03);
		chk("empty tree output", 12'h000, 12'(gout[2]));
		pins = 6'h02;
		wait_for(0, 0, 1'b0, 5, 14);
		wait_for(1, 0, 1'b0, 0, 8);
		wait_for(0, 1, 1'b0, 0, 10);
		// sleep request on pin 3, low means sleep
		wr_reg(8'h50, 8'h30);
		wr_reg(8'h51, 8'h10);
		wr_reg(8'h4D, 8'h01);
		cyc(4);
		chk("sleep code", 12'h010, 12'(vid));
		pins = 6'h06;
		cyc(4);
		chk("normal code", 12'h030, 12'(vid));
		// software control of the first LDO and a switch, then emergency
		wr_reg(8'h26, 8'h08);
		wr_reg(8'h29, 8'h08);
		wr_reg(8'h64, 8'h40);
		wr_reg(8'h65, 8'h02);
		chk("software enables", 12'h240, rail_en);
		emerg = 1'b1;
		cyc(4);
		chk("emergency enables", 12'h040, rail_en);
		emerg = 1'b0;
		wr_reg(8'h65, 8'h00);
		cyc(2);
		chk("software off", 12'h040, rail_en);
		// a short pin pulse (two ticks at most) must leave no partial count behind
		wr_reg(8'h44, 8'h01);
		pins = 6'h07;
		cyc(8);
		pins = 6'h06;
		cyc(4);
		chk("rail after short pulse", 12'h000, 12'(rail_en[0]));
		// undervoltage: goods first, rails later
		pins = 6'h07;
		wait_for(0, 0, 1'b1, 8, 18);
		wait_for(1, 0, 1'b1, 0, 16);
		// third output asks 0 ms but is held to its 5 ms floor: three ticks after the first
		wait_for(1, 2, 1'b1, 10, 14);
		supply = 1'b0;
		cyc(4);
		chk("good at undervoltage", 12'h000, 12'(gout[0]));
		chk("rail at undervoltage", 12'h001, 12'(rail_en[0]));
		wait_for(0, 0, 1'b0, 10, 22);
		chk("all rails after undervoltage", 12'h000, rail_en);
		stop_test();
	end
endmodule // rail_sequencer_power_good_tb_top
